// >>> fds_pkg.sv
// package for the fractional dot-subtract datapath
// assumes a single 250 MHz core clock domain and decoded 32-bit words
package fds_pkg;
    // ========================================================
    // instruction fields
    localparam logic [5:0] FDS_MAJOR_EXT = 6'h1F; // extension_major_opcode
    localparam logic [5:0] FDS_FUNC_DOT = 6'h30; // dot_product_function_group
    localparam logic [4:0] FDS_SUB_HALF = 5'h05;
    localparam logic [4:0] FDS_SUB_WORD = 5'h0D;
    localparam logic [4:0] FDS_SUB_CROSS = 5'h19;
    localparam int FDS_MAJOR_LSB = 26;
    localparam int FDS_SEL_LSB = 11;
    localparam int FDS_SUB_LSB = 6;
    // ========================================================
    // status register and constants
    localparam int FDS_FLAG_LSB = 16;
    localparam logic [3:0] FDS_FLAG_RESET = 4'h0;
    localparam logic [63:0] FDS_ACC_RESET = 64'h0000000000000000;
    localparam logic [15:0] FDS_Q15_NEG_ONE = 16'h8000;
    localparam logic [31:0] FDS_Q31_NEG_ONE = 32'h80000000;
    localparam logic [31:0] FDS_Q31_MAX = 32'h7FFFFFFF;
    localparam logic [63:0] FDS_Q63_MAX = 64'h7FFFFFFFFFFFFFFF;
    localparam logic [63:0] FDS_Q63_MIN = 64'h8000000000000000;

    typedef enum logic [1:0] {
        FDS_OP_NONE = 2'b00,
        FDS_OP_HALF = 2'b01,
        FDS_OP_CROSS = 2'b10,
        FDS_OP_WORD = 2'b11
    } fds_op_type;
endpackage : fds_pkg

// >>> fds_q15_mul.sv
// one saturating Q15 x Q15 -> Q31 multiplier lane
// assumes purely combinational use inside the datapath
`timescale 1ns/100ps
module fds_q15_mul
    import fds_pkg::*;
(
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    output logic [31:0] prod,
    output logic sat
);
    // ========================================================
    // multiply, shift, and patch the -1 x -1 corner
    logic signed [31:0] raw;
    assign raw = $signed(a) * $signed(b);
    assign sat = (a == FDS_Q15_NEG_ONE) && (b == FDS_Q15_NEG_ONE);
    assign prod = sat ? FDS_Q31_MAX : {raw[30:0], 1'h0};
endmodule : fds_q15_mul

// >>> fds_datapath.sv
// fractional dot-subtract execution datapath with four accumulators
// assumes the core pipeline hands one decoded word per valid cycle
// and the exception unit reports reserved or dsp-disabled conditions
`timescale 1ns/100ps
module fds_datapath
    import fds_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic issue_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] source_one_value,
    input wire logic [31:0] source_two_value,
    input wire logic reserved_instr_exc,
    input wire logic dsp_disabled_exc,
    input wire logic [1:0] read_select,
    output logic [31:0] upper_sum_word,
    output logic [31:0] bottom_sum_word,
    output logic [3:0] dsp_status_flags,
    output logic op_accepted,
    output logic op_blocked
);
    // ========================================================
    // decode helpers
    function automatic fds_op_type decode_op(input logic [31:0] w);
        fds_op_type op;
        op = FDS_OP_NONE;
        if (w[31:FDS_MAJOR_LSB] == FDS_MAJOR_EXT && w[5:0] == FDS_FUNC_DOT
            && w[15:13] == 3'h0) begin
            unique case (w[10:FDS_SUB_LSB])
                FDS_SUB_HALF: op = FDS_OP_HALF;
                FDS_SUB_WORD: op = FDS_OP_WORD;
                FDS_SUB_CROSS: op = FDS_OP_CROSS;
                default: op = FDS_OP_NONE;
            endcase
        end
        return op;
    endfunction : decode_op

    fds_op_type op;
    logic [1:0] sel;
    logic is_half;
    logic do_update;
    assign op = decode_op(instr_word);
    assign sel = instr_word[FDS_SEL_LSB+1:FDS_SEL_LSB];
    assign is_half = (op == FDS_OP_HALF) || (op == FDS_OP_CROSS);
    // exceptions win over any update; operand values never trap
    assign do_update = issue_valid && (op != FDS_OP_NONE)
        && !reserved_instr_exc && !dsp_disabled_exc;
    assign op_accepted = do_update;
    assign op_blocked = issue_valid && (op != FDS_OP_NONE) && !do_update;

    // ========================================================
    // accumulator storage, index zero is the original pair
    logic [63:0] acc_q [4];
    logic [63:0] acc_sel;
    logic [3:0] flags_q;
    assign acc_sel = acc_q[sel];

    // ========================================================
    // halfword lanes; cross form swaps source two halves
    logic [15:0] lane_b_hi;
    logic [15:0] lane_b_lo;
    logic [31:0] prod_hi;
    logic [31:0] prod_lo;
    logic sat_hi;
    logic sat_lo;
    assign lane_b_hi = (op == FDS_OP_CROSS) ? source_two_value[15:0]
        : source_two_value[31:16];
    assign lane_b_lo = (op == FDS_OP_CROSS) ? source_two_value[31:16]
        : source_two_value[15:0];

    fds_q15_mul u_mul_hi (
        .a(source_one_value[31:16]),
        .b(lane_b_hi),
        .prod(prod_hi),
        .sat(sat_hi)
    );
    fds_q15_mul u_mul_lo (
        .a(source_one_value[15:0]),
        .b(lane_b_lo),
        .prod(prod_lo),
        .sat(sat_lo)
    );

    // sum and subtract, wraps on purpose: no clamping here
    logic [63:0] dot_sum;
    logic [63:0] half_result;
    logic half_sat;
    assign dot_sum = {{32{prod_hi[31]}}, prod_hi}
        + {{32{prod_lo[31]}}, prod_lo};
    assign half_result = acc_sel - dot_sum;
    assign half_sat = sat_hi || sat_lo;

    // ========================================================
    // word lane: Q31 x Q31 -> Q63, then 65-bit subtract and clamp
    logic signed [63:0] word_raw;
    logic word_prod_sat;
    logic [63:0] word_prod;
    logic [64:0] word_diff;
    logic word_acc_sat;
    logic [63:0] word_result;
    assign word_raw = $signed(source_one_value) * $signed(source_two_value);
    assign word_prod_sat = (source_one_value == FDS_Q31_NEG_ONE)
        && (source_two_value == FDS_Q31_NEG_ONE);
    assign word_prod = word_prod_sat ? FDS_Q63_MAX
        : {word_raw[62:0], 1'h0};
    assign word_diff = {acc_sel[63], acc_sel} - {word_prod[63], word_prod};
    assign word_acc_sat = word_diff[64] != word_diff[63];
    assign word_result = !word_acc_sat ? word_diff[63:0]
        : (word_diff[64] ? FDS_Q63_MIN : FDS_Q63_MAX);

    // ========================================================
    // next values
    logic [63:0] new_acc;
    logic new_sat;
    logic [3:0] flags_d;
    assign new_acc = is_half ? half_result : word_result;
    assign new_sat = is_half ? half_sat
        : (word_prod_sat || word_acc_sat);
    // set-only: a flag already high stays high
    assign flags_d = flags_q
        | ((do_update && new_sat) ? (4'h1 << sel) : 4'h0);

    // accumulators update only on an accepted op
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                acc_q[i] <= FDS_ACC_RESET;
            end
        end else if (do_update) begin
            acc_q[sel] <= new_acc;
        end
    end

    // status flags, bits 16..19 of the wider register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags_q <= FDS_FLAG_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ========================================================
    // read port, registered so data outputs come from flops
    always_ff @(posedge clk) begin
        if (!resetn) begin
            upper_sum_word <= FDS_ACC_RESET[63:32];
            bottom_sum_word <= FDS_ACC_RESET[31:0];
        end else begin
            upper_sum_word <= acc_q[read_select][63:32];
            bottom_sum_word <= acc_q[read_select][31:0];
        end
    end
    assign dsp_status_flags = flags_q;

    // ========================================================
    // checks
    // flags may only rise outside reset, every bit watched
    a_flag_sticky: assert property (
        @(posedge clk) disable iff (!resetn)
        (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("status flag cleared");
    // only the selected flag may newly rise
    a_flag_no_other: assert property (
        @(posedge clk) disable iff (!resetn)
        do_update |=> (flags_q & ~$past(flags_q)
        & ~(4'h1 << $past(sel))) == 4'h0)
        else $error("wrong flag bit raised");
    // exceptions leave flags and accumulators alone
    a_exc_blocks_flags: assert property (
        @(posedge clk) disable iff (!resetn)
        (issue_valid && (reserved_instr_exc || dsp_disabled_exc))
        |=> flags_q == $past(flags_q))
        else $error("flag changed under exception");
    a_idle_holds_acc: assert property (
        @(posedge clk) disable iff (!resetn)
        !do_update |=> acc_q[$past(sel)] == $past(acc_sel))
        else $error("accumulator changed without update");
    // halfword product corners and write-back
    a_half_corner_sat: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && is_half && source_one_value[15:0] == FDS_Q15_NEG_ONE
        && lane_b_lo == FDS_Q15_NEG_ONE) |=> flags_q[$past(sel)])
        else $error("halfword saturation not flagged");
    a_half_corner_hi: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && is_half && source_one_value[31:16] == FDS_Q15_NEG_ONE
        && lane_b_hi == FDS_Q15_NEG_ONE) |=> flags_q[$past(sel)])
        else $error("upper halfword saturation not flagged");
    a_half_no_acc_flag: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && is_half && !sat_hi && !sat_lo && flags_q == 4'h0)
        |=> flags_q == 4'h0)
        else $error("subtract set flag in halfword form");
    a_half_writeback: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && is_half) |=> acc_q[$past(sel)] == $past(half_result))
        else $error("halfword result not written");
    // word product corner, clamps and write-back
    a_word_corner: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && op == FDS_OP_WORD && word_prod_sat)
        |=> flags_q[$past(sel)])
        else $error("word product saturation not flagged");
    a_word_clamp_pos: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && op == FDS_OP_WORD && word_acc_sat && !word_diff[64])
        |=> acc_q[$past(sel)] == FDS_Q63_MAX)
        else $error("positive clamp wrong");
    a_word_clamp_neg: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && op == FDS_OP_WORD && word_acc_sat && word_diff[64])
        |=> acc_q[$past(sel)] == FDS_Q63_MIN)
        else $error("negative clamp wrong");
    a_word_writeback: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && op == FDS_OP_WORD)
        |=> acc_q[$past(sel)] == $past(word_result))
        else $error("word result not written");
    a_word_quiet_flag: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && op == FDS_OP_WORD && !word_prod_sat && !word_acc_sat)
        |=> flags_q == $past(flags_q))
        else $error("word form flagged without saturation");
    a_word_flag_map: assert property (
        @(posedge clk) disable iff (!resetn)
        (do_update && new_sat && sel == 2'h3) |=> flags_q[3])
        else $error("flag bit mapping wrong");
    // decode refusal and read port
    a_decode_half: assert property (
        @(posedge clk) disable iff (!resetn)
        (issue_valid && instr_word[15:13] != 3'h0) |-> !op_accepted)
        else $error("nonzero bits 15..13 accepted");
    a_read_port_data: assert property (
        @(posedge clk) disable iff (!resetn)
        1'h1 |=> {upper_sum_word, bottom_sum_word}
        == $past(acc_q[read_select]))
        else $error("read port shows wrong accumulator");
endmodule : fds_datapath

// >>> fds_core_model.sv
// core pipeline model: issues decoded words and operands to the datapath
// assumes the bench calls issue and idle just after a rising edge
`timescale 1ns/100ps
module fds_core_model (
    input wire logic clk,
    output logic issue_valid,
    output logic [31:0] instr_word,
    output logic [31:0] source_one_value,
    output logic [31:0] source_two_value
);
    // ========================================================
    // issue side, quiet at time zero
    initial begin
        issue_valid = 1'h0;
        instr_word = 32'h0;
        source_one_value = 32'h0;
        source_two_value = 32'h0;
    end

    // one word per call; calls in a row give back-to-back issue
    task automatic issue(input logic [31:0] w, a, b);
        @(posedge clk);
        #1;
        issue_valid = 1'h1;
        instr_word = w;
        source_one_value = a;
        source_two_value = b;
    endtask : issue

    // the pipeline moves on, so operands no longer hold their value
    task automatic idle();
        @(posedge clk);
        #1;
        issue_valid = 1'h0;
        instr_word = ~instr_word;
        source_one_value = ~source_one_value;
        source_two_value = ~source_two_value;
    endtask : idle
endmodule : fds_core_model

// >>> tb_fractional_dot_subtract.sv
// self-checking bench for the fractional dot-subtract datapath
// assumes fds_core_model on the issue side; expectations kept here
`timescale 1ns/100ps
module tb_fractional_dot_subtract
    import fds_pkg::*;
;
    typedef struct packed {
        logic [4:0] sub;
        logic [1:0] sel;
        logic [31:0] a;
        logic [31:0] b;
        logic [3:0] flg;
    } fds_tb_row_type;
    // ========================================================
    // ordinary cases; word rows 4..7 walk acc 0 and 3 into clamps
    // last column: flag field expected after the row
    localparam fds_tb_row_type ROWS [9] = '{
        '{FDS_SUB_HALF, 2'h0, 32'h40002000, 32'h20004000, 4'h0},
        '{FDS_SUB_HALF, 2'h1, 32'h80008000, 32'h80000001, 4'h2},
        '{FDS_SUB_CROSS, 2'h2, 32'h80000003, 32'h7FFF8000, 4'h6},
        '{FDS_SUB_CROSS, 2'h3, 32'hFFFF1234, 32'h5678FFFE, 4'h6},
        '{FDS_SUB_WORD, 2'h0, 32'h80000000, 32'h80000000, 4'h7},
        '{FDS_SUB_WORD, 2'h0, 32'h7FFFFFFF, 32'h7FFFFFFF, 4'h7},
        '{FDS_SUB_WORD, 2'h3, 32'h80000000, 32'h7FFFFFFF, 4'h7},
        '{FDS_SUB_WORD, 2'h3, 32'h80000000, 32'h7FFFFFFF, 4'hF},
        '{FDS_SUB_HALF, 2'h3, 32'h00010001, 32'hFFFFFFFF, 4'hF}};
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic exc_r = 1'h0;
    logic exc_d = 1'h0;
    logic [1:0] read_select = 2'h0;
    logic issue_valid, op_accepted, op_blocked;
    logic [31:0] instr_word, source_one_value, source_two_value;
    logic [31:0] upper_sum_word, bottom_sum_word;
    logic [3:0] dsp_status_flags;
    logic [63:0] acc_e [4];
    logic [3:0] flg_e;
    int err_total = 0;
    int num_checks = 0;

    always #2 clk = ~clk;
    fds_core_model core_u (.clk(clk), .issue_valid(issue_valid),
        .instr_word(instr_word), .source_one_value(source_one_value),
        .source_two_value(source_two_value));
    fds_datapath dut_u (.clk(clk), .resetn(resetn),
        .issue_valid(issue_valid), .instr_word(instr_word),
        .source_one_value(source_one_value),
        .source_two_value(source_two_value),
        .reserved_instr_exc(exc_r), .dsp_disabled_exc(exc_d),
        .read_select(read_select), .upper_sum_word(upper_sum_word),
        .bottom_sum_word(bottom_sum_word),
        .dsp_status_flags(dsp_status_flags),
        .op_accepted(op_accepted), .op_blocked(op_blocked));
    // ========================================================
    // reference model; bit 32 of a lane marks its saturation
    function automatic logic [32:0] q15(input logic [15:0] x, y);
        logic signed [31:0] m;
        m = $signed(x) * $signed(y);
        if (x == FDS_Q15_NEG_ONE && y == FDS_Q15_NEG_ONE)
            return {1'h1, FDS_Q31_MAX};
        return {1'h0, m[30:0], 1'h0};
    endfunction : q15

    function automatic logic [31:0] mk(input logic [4:0] u, logic [1:0] s);
        return {FDS_MAJOR_EXT, 13'h0, s, u, FDS_FUNC_DOT};
    endfunction : mk

    task automatic ref_op(input logic [31:0] w, a, b);
        logic [1:0] s;
        logic c;
        logic [32:0] p1, p2;
        logic signed [63:0] pw;
        logic signed [64:0] t;
        s = w[12:11];
        c = w[10:6] == FDS_SUB_CROSS;
        if (w[10:6] == FDS_SUB_WORD) begin
            pw = $signed(a) * $signed(b);
            c = a == FDS_Q31_NEG_ONE && b == FDS_Q31_NEG_ONE;
            pw = c ? FDS_Q63_MAX : pw <<< 1;
            t = $signed({acc_e[s][63], acc_e[s]}) - pw;
            // flag first: the clamp makes the top bits agree again
            flg_e[s] |= c | (t[64] != t[63]);
            if (t[64] != t[63])
                t[63:0] = t[64] ? FDS_Q63_MIN : FDS_Q63_MAX;
            acc_e[s] = t[63:0];
        end else begin
            p1 = q15(a[31:16], c ? b[15:0] : b[31:16]);
            p2 = q15(a[15:0], c ? b[31:16] : b[15:0]);
            pw = $signed(p1[31:0]) + $signed(p2[31:0]);
            acc_e[s] = acc_e[s] - pw;
            flg_e[s] |= p1[32] | p2[32];
        end
    endtask : ref_op
    // ========================================================
    // comparison, read-back and issue helpers
    task automatic chk(input logic [63:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic rd(input logic [1:0] s);
        read_select = s;
        @(posedge clk);
        #1;
        chk({upper_sum_word, bottom_sum_word}, acc_e[s], "acc");
        chk(64'(dsp_status_flags), 64'(flg_e), "flags");
    endtask : rd

    task automatic run_op(input logic [31:0] w, a, b);
        logic ok, hit;
        hit = w[31:26] == FDS_MAJOR_EXT && w[5:0] == FDS_FUNC_DOT
            && w[15:13] == 3'h0 && (w[10:6] == FDS_SUB_HALF
            || w[10:6] == FDS_SUB_WORD || w[10:6] == FDS_SUB_CROSS);
        ok = hit && !exc_r && !exc_d;
        core_u.issue(w, a, b);
        #1;
        chk(64'(op_accepted), 64'(ok), "accept");
        chk(64'(op_blocked), 64'(hit && !ok), "blocked");
        if (ok)
            ref_op(w, a, b);
        core_u.idle();
        rd(w[12:11]);
    endtask : run_op

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    // ========================================================
    // main sequence, then the watchdog
    initial begin
        foreach (acc_e[i]) acc_e[i] = FDS_ACC_RESET;
        flg_e = FDS_FLAG_RESET;
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'h1;
        for (int i = 0; i < 4; i++) rd(2'(i));
        $display("test reset done");
        foreach (ROWS[i]) begin
            run_op(mk(ROWS[i].sub, ROWS[i].sel), ROWS[i].a,
                ROWS[i].b);
            chk(64'(dsp_status_flags), 64'(ROWS[i].flg), "row flags");
        end
        $display("test rows done");
        exc_r = 1'h1;
        run_op(mk(FDS_SUB_WORD, 2'h2), 32'h80000000, 32'h80000000);
        exc_r = 1'h0;
        exc_d = 1'h1;
        run_op(mk(FDS_SUB_HALF, 2'h1), 32'h80008000, 32'h80008000);
        exc_d = 1'h0;
        run_op(mk(FDS_SUB_HALF, 2'h2) | 32'h2000, 32'h8000, 32'h8000);
        run_op(mk(5'h07, 2'h2), 32'h8000, 32'h8000);
        run_op(mk(FDS_SUB_CROSS, 2'h2) ^ 32'h04000000, 32'h1, 32'h1);
        $display("test refusals done");
        // second op must see the first op's result
        core_u.issue(mk(FDS_SUB_CROSS, 2'h1), 32'h12345678, 32'h9ABCDEF0);
        ref_op(mk(FDS_SUB_CROSS, 2'h1), 32'h12345678, 32'h9ABCDEF0);
        core_u.issue(mk(FDS_SUB_CROSS, 2'h1), 32'h80008000, 32'h80008000);
        ref_op(mk(FDS_SUB_CROSS, 2'h1), 32'h80008000, 32'h80008000);
        core_u.idle();
        rd(2'h1);
        $display("test back to back done");
        resetn = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'h1;
        foreach (acc_e[i]) acc_e[i] = FDS_ACC_RESET;
        flg_e = FDS_FLAG_RESET;
        for (int i = 0; i < 4; i++) rd(2'(i));
        $display("test mid reset done");
        complete_run();
    end

    initial begin
        #8000;
        err_total++;
        $display("watchdog expired");
        complete_run();
    end
endmodule : tb_fractional_dot_subtract
